// ==== idsrc_map.svh ====
// Purpose: offsets, fields and reset values of the interrupt source
// Assumes: 32-bit configuration doublewords
// Notes: bit numbers count within one doubleword
`ifndef IDSRC_MAP_SVH
`define IDSRC_MAP_SVH
// -----------------------------------------------------------------
// capability header
// -----------------------------------------------------------------
`define IDSRC_CAP_ID 8'h08
`define IDSRC_CAP_TYPE 8'h80
`define IDSRC_IDX_LSB 16
`define IDSRC_IDX_MSB 23
// -----------------------------------------------------------------
// indexes
// -----------------------------------------------------------------
`define IDSRC_IDX_LAST 8'h01
`define IDSRC_IDX_BASE 8'h10
`define IDSRC_LAST_LSB 16
`define IDSRC_LAST_MSB 23
// -----------------------------------------------------------------
// definition register fields
// -----------------------------------------------------------------
`define IDSRC_LO_RST 32'hF800_0001
`define IDSRC_HI_RW 32'h00FF_FFFF
`define IDSRC_ZERO32 32'h0000_0000
`define IDSRC_B_MASK 0
`define IDSRC_B_POL 1
`define IDSRC_B_REQUEST_END_OF_INTERRUPT 5
`define IDSRC_B_PPW 30
`define IDSRC_B_EOI 31
`define IDSRC_INFO_LSB 2
`define IDSRC_HI_INFO_MSB 23
`endif

// ==== idsrc_pkg.sv ====
// Purpose: shared types of the interrupt definition source
// Assumes: nothing beyond the map header
// Notes: info field type spans the message payload bits 55:2
package idsrc_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_HOLD = 2'h1,
        TX_SEND = 2'h3
    } idsrc_tx_type;
    typedef enum logic [1:0] {
        ORD_BOTH = 2'h0,
        ORD_STRICT = 2'h1,
        ORD_RELAX = 2'h2
    } idsrc_ord_type;
    typedef logic [55:2] idsrc_info_type;
endpackage

// ==== idsrc_evt_if.sv ====
// Purpose: carrier between register file, trigger and sender
// Assumes: one clock
// Notes: vectors are indexed by interrupt number
`timescale 1ns/100ps
`default_nettype none
interface idsrc_evt_if #(parameter int NUM_INT = 4);
    import idsrc_pkg::*;
    logic [NUM_INT-1:0] src_lvl;
    logic [NUM_INT-1:0] pol;
    logic [NUM_INT-1:0] mask;
    logic [NUM_INT-1:0] hold;
    logic [NUM_INT-1:0] want;
    logic [NUM_INT-1:0] sent;
    logic [7:0] sel_idx;
    idsrc_info_type sel_info;
    logic sel_ppw;
    modport trig (input src_lvl, pol, mask, hold, sent, output want);
    modport tx (input want, sel_info, sel_ppw, output sel_idx, sent);
    modport top (output src_lvl, pol, mask, hold, sel_info, sel_ppw,
                 input want, sel_idx, sent);
endinterface
`default_nettype wire

// ==== idsrc_trig.sv ====
// Purpose: per-source trigger qualification
// Assumes: source inputs synchronous to core_clk
// Notes: one message per assertion; a new one needs the level to drop
`timescale 1ns/100ps
`default_nettype none
module idsrc_trig
    import idsrc_pkg::*;
#(
    parameter int NUM_INT = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    idsrc_evt_if.trig evt
);
    genvar g;
    generate
        for (g = 0; g < NUM_INT; g++) begin : g_src
            logic act;
            logic fired_ff;
            assign act = evt.src_lvl[g] ^ evt.pol[g];
            // sent wins so a source that drops at once is not re-fired
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    fired_ff <= 1'h0;
                end else if (evt.sent[g]) begin
                    fired_ff <= 1'h1;
                end else if (!act) begin
                    fired_ff <= 1'h0;
                end
            end
            // masked or waiting sources raise no request
            assign evt.want[g] = act & ~evt.mask[g] & ~evt.hold[g] & ~fired_ff;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== idsrc_msg_tx.sv ====
// Purpose: picks one wanting source and sends its message upstream
// Assumes: posted_busy is high while older posted writes are queued
// Notes: lowest interrupt number wins; payload is frozen at pick time
`timescale 1ns/100ps
`default_nettype none
module idsrc_msg_tx
    import idsrc_pkg::*;
#(
    parameter int NUM_INT = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    idsrc_evt_if.tx evt,
    input wire logic posted_busy,
    output logic msg_valid,
    input wire logic msg_ready,
    output idsrc_info_type msg_info,
    output logic msg_pass_pw,
    output logic [7:0] msg_src
);
    idsrc_tx_type state_ff;
    idsrc_tx_type nxt_state;
    logic any_want;
    logic [7:0] pick;

    always_comb begin
        any_want = 1'h0;
        pick = 8'h00;
        for (int i = NUM_INT - 1; i >= 0; i--) begin
            if (evt.want[i]) begin
                any_want = 1'h1;
                pick = 8'(i);
            end
        end
    end
    assign evt.sel_idx = pick;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            TX_IDLE: if (any_want) nxt_state = evt.sel_ppw ? TX_SEND : TX_HOLD;
            TX_HOLD: if (!posted_busy) nxt_state = TX_SEND;
            TX_SEND: if (msg_ready) nxt_state = TX_IDLE;
            default: nxt_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= TX_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            msg_info <= '0;
            msg_pass_pw <= 1'h0;
            msg_src <= 8'h00;
        end else if (state_ff == TX_IDLE && any_want) begin
            msg_info <= evt.sel_info;
            msg_pass_pw <= evt.sel_ppw;
            msg_src <= pick;
        end
    end

    assign msg_valid = (state_ff == TX_SEND);

    genvar g;
    generate
        for (g = 0; g < NUM_INT; g++) begin : g_sent
            assign evt.sent[g] = msg_valid & msg_ready & (msg_src == 8'(g));
        end
    endgenerate
endmodule
`default_nettype wire

// ==== idsrc_top.sv ====
// Purpose: interrupt definition registers and upstream message source
// Assumes: config reads and writes never in the same cycle
// Notes: registers reached through an index and a dataport doubleword
`timescale 1ns/100ps
`default_nettype none
`include "idsrc_map.svh"

// What this block does
// - each interrupt owns two indexes from 10h
// - even index low word, odd index high
// - warm reset restores every field default
// - eoi_pending set on a send that requests eoi (bit 5), cleared on eoi
// - no new request while eoi_pending stands
// - relax control one sends pass flag set
// - relax zero: flag clear, wait posted writes
// - single-behaviour device makes relax control read-only
// - info bits 31:24 reset to F8h
// - message type rides in info bits 4:2
// - polarity bit selects active-low external input
// - mask blocks messages and resets to one
// - index 01h reports highest interrupt number
module idsrc_top
    import idsrc_pkg::*;
#(
    parameter int NUM_INT = 4,
    parameter logic [NUM_INT-1:0] EXT_SRC = '1,
    parameter idsrc_ord_type ORD_MODE = ORD_BOTH,
    parameter logic [7:0] CAP_PTR = 8'h00
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic cfg_dw_sel,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic [NUM_INT-1:0] src_in,
    input wire logic posted_busy,
    output logic msg_valid,
    input wire logic msg_ready,
    output idsrc_info_type msg_info,
    output logic msg_pass_pw,
    output logic [7:0] msg_src,
    input wire logic eoi_valid,
    input wire logic [7:0] eoi_src
);

    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    logic [7:0] index_ff;
    logic [31:0] def_lo_ff [NUM_INT];
    logic [`IDSRC_HI_INFO_MSB:0] def_hi_ff [NUM_INT];
    logic [NUM_INT-1:0] ppw_ff;
    logic [NUM_INT-1:0] eoi_ff;

    // -------------------------------------------------------------
    // index decode
    // -------------------------------------------------------------
    logic [8:0] idx_off;
    logic def_hit;
    logic [7:0] def_sel;
    logic def_odd;
    logic hdr_wr;
    logic port_wr;

    assign idx_off = {1'h0, index_ff} - {1'h0, `IDSRC_IDX_BASE};
    assign def_sel = idx_off[8:1];
    assign def_odd = index_ff[0];

    // an index below the base wraps idx_off high and misses
    assign def_hit = (index_ff >= `IDSRC_IDX_BASE) &&
                     (def_sel < 8'(NUM_INT));

    // byte lanes are not decoded: the port is a whole doubleword
    assign hdr_wr = cfg_wr & ~cfg_dw_sel;
    assign port_wr = cfg_wr & cfg_dw_sel & def_hit;

    // -------------------------------------------------------------
    // index register
    // -------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            index_ff <= 8'h00;
        end else if (hdr_wr) begin
            index_ff <= cfg_wdata[`IDSRC_IDX_MSB:`IDSRC_IDX_LSB];
        end
    end

    // -------------------------------------------------------------
    // carrier towards trigger and sender
    // -------------------------------------------------------------
    idsrc_evt_if #(.NUM_INT(NUM_INT)) evt ();

    assign evt.src_lvl = src_in;

    // -------------------------------------------------------------
    // per-interrupt definition registers
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_INT; g++) begin : g_def
            logic wr_lo;
            logic wr_hi;
            logic [31:0] nxt_lo;
            logic eoi_set;
            logic eoi_clr;

            assign wr_lo = port_wr & (def_sel == 8'(g)) & ~def_odd;
            assign wr_hi = port_wr & (def_sel == 8'(g)) & def_odd;

            // polarity has no meaning for internal sources
            always_comb begin
                nxt_lo = cfg_wdata;
                if (!EXT_SRC[g]) begin
                    nxt_lo[`IDSRC_B_POL] = 1'h0;
                end
            end

            // mask set and info 31:24 at F8h out of reset
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    def_lo_ff[g] <= `IDSRC_LO_RST;
                end else if (wr_lo) begin
                    def_lo_ff[g] <= nxt_lo;
                end
            end

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    def_hi_ff[g] <= '0;
                end else if (wr_hi) begin
                    def_hi_ff[g] <= cfg_wdata[`IDSRC_HI_INFO_MSB:0];
                end
            end

            // fixed-ordering builds never let software move this bit
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    ppw_ff[g] <= (ORD_MODE == ORD_RELAX);
                end else if (wr_hi && ORD_MODE == ORD_BOTH) begin
                    ppw_ff[g] <= cfg_wdata[`IDSRC_B_PPW];
                end
            end

            // hardware set beats a returning eoi or a software clear
            assign eoi_set = evt.sent[g] & def_lo_ff[g][`IDSRC_B_REQUEST_END_OF_INTERRUPT];
            assign eoi_clr = (eoi_valid && eoi_src == 8'(g)) ||
                             (wr_hi && cfg_wdata[`IDSRC_B_EOI]);

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    eoi_ff[g] <= 1'h0;
                end else if (eoi_set) begin
                    eoi_ff[g] <= 1'h1;
                end else if (eoi_clr) begin
                    eoi_ff[g] <= 1'h0;
                end
            end

            assign evt.mask[g] = def_lo_ff[g][`IDSRC_B_MASK];
            assign evt.pol[g] = def_lo_ff[g][`IDSRC_B_POL];
            // only set while end-of-interrupt is requested
            assign evt.hold[g] = eoi_ff[g];
        end
    endgenerate

    // -------------------------------------------------------------
    // payload of the source the sender picks
    // -------------------------------------------------------------
    always_comb begin
        evt.sel_info = '0;
        evt.sel_ppw = 1'h0;
        for (int i = 0; i < NUM_INT; i++) begin
            if (evt.sel_idx == 8'(i)) begin
                evt.sel_info = {def_hi_ff[i],
                                def_lo_ff[i][31:`IDSRC_INFO_LSB]};
                evt.sel_ppw = ppw_ff[i];
            end
        end
    end

    // -------------------------------------------------------------
    // trigger and sender
    // -------------------------------------------------------------
    idsrc_trig #(
        .NUM_INT(NUM_INT)
    ) u_trig (
        .core_clk(core_clk),
        .srst(srst),
        .evt(evt)
    );

    idsrc_msg_tx #(
        .NUM_INT(NUM_INT)
    ) u_tx (
        .core_clk(core_clk),
        .srst(srst),
        .evt(evt),
        .posted_busy(posted_busy),
        .msg_valid(msg_valid),
        .msg_ready(msg_ready),
        .msg_info(msg_info),
        .msg_pass_pw(msg_pass_pw),
        .msg_src(msg_src)
    );

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    logic [31:0] hdr_word;
    logic [31:0] port_word;
    logic [7:0] last_int;

    assign last_int = 8'(NUM_INT - 1);
    assign hdr_word = {`IDSRC_CAP_TYPE, index_ff, CAP_PTR, `IDSRC_CAP_ID};

    always_comb begin
        port_word = `IDSRC_ZERO32;
        if (index_ff == `IDSRC_IDX_LAST) begin
            port_word[`IDSRC_LAST_MSB:`IDSRC_LAST_LSB] = last_int;
        end else if (def_hit) begin
            for (int i = 0; i < NUM_INT; i++) begin
                if (def_sel == 8'(i)) begin
                    if (def_odd) begin
                        port_word[`IDSRC_HI_INFO_MSB:0] = def_hi_ff[i];
                        port_word[`IDSRC_B_PPW] = ppw_ff[i];
                        port_word[`IDSRC_B_EOI] = eoi_ff[i];
                    end else begin
                        port_word = def_lo_ff[i];
                    end
                end
            end
        end
    end

    // reserved indexes fall through and read as zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_rdata <= `IDSRC_ZERO32;
        end else if (cfg_rd) begin
            cfg_rdata <= cfg_dw_sel ? port_word : hdr_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_rvalid <= 1'h0;
        end else begin
            cfg_rvalid <= cfg_rd;
        end
    end

endmodule
`default_nettype wire

// ==== idsrc_properties.sv ====
// Purpose: port-level assertions for idsrc_top
// Assumes: one clock, srst synchronous active high
// Notes: bound into every idsrc_top instance
`timescale 1ns/100ps
`default_nettype none
module idsrc_checker
    import idsrc_pkg::*;
#(
    parameter int NUM_INT = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic cfg_dw_sel,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic [NUM_INT-1:0] src_in,
    input wire logic posted_busy,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire idsrc_info_type msg_info,
    input wire logic msg_pass_pw,
    input wire logic [7:0] msg_src,
    input wire logic eoi_valid,
    input wire logic [7:0] eoi_src
);
    // ------
    // assertions
    // ------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    rvalid_pulse_a: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read answer missing");
    rvalid_idle_a: assert property (!cfg_rd |=> !cfg_rvalid)
        else $error("read answer without read");
    rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved without read");
    header_read_a: assert property (cfg_rd && !cfg_dw_sel |=>
        cfg_rdata[7:0] == 8'h08 && cfg_rdata[31:24] == 8'h80)
        else $error("header word wrong");
    // a held offer must not change under the host
    msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid
        && $stable(msg_info) && $stable(msg_src) && $stable(msg_pass_pw))
        else $error("message dropped or changed while offered");
    accept_gap_a: assert property (msg_valid && msg_ready |=> !msg_valid)
        else $error("message offered right after accept");
    src_range_a: assert property (msg_valid |-> msg_src < NUM_INT)
        else $error("message from undefined interrupt");
    posted_order_a: assert property ($rose(msg_valid) && !msg_pass_pw
        |-> !$past(posted_busy))
        else $error("ordered message passed posted writes");
    reset_quiet_a: assert property (disable iff (1'b0) srst
        |=> !msg_valid && !cfg_rvalid)
        else $error("outputs active after reset");
    cover property (msg_valid && msg_ready && msg_pass_pw);
    cover property (msg_valid && msg_ready && !msg_pass_pw);
    cover property (msg_valid && !msg_ready);
endmodule
bind idsrc_top idsrc_checker #(.NUM_INT(NUM_INT)) u_chk (
    .core_clk(core_clk), .srst(srst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_dw_sel(cfg_dw_sel), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .src_in(src_in), .posted_busy(posted_busy),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_info(msg_info),
    .msg_pass_pw(msg_pass_pw), .msg_src(msg_src), .eoi_valid(eoi_valid),
    .eoi_src(eoi_src)
);
`default_nettype wire

// ==== idsrc_host_model.sv ====
// Purpose: host side that accepts interrupt messages and returns eoi
// Assumes: signals change 1 ns after the rising edge
// Notes: alternates prompt and three-cycle slow acceptance
`timescale 1ns/100ps
`default_nettype none
module idsrc_host_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic msg_valid,
    input wire logic [7:0] msg_src,
    input wire logic eoi_en,
    output logic msg_ready,
    output logic eoi_valid,
    output logic [7:0] eoi_src
);
    int stall;
    int eoi_wait;
    int turn;
    logic took;
    logic [7:0] id;
    initial begin
        msg_ready = 1'b0;
        eoi_valid = 1'b0;
        eoi_src = 8'h00;
        stall = 0;
        eoi_wait = -1;
        turn = 0;
        id = 8'h00;
        forever begin
            @(posedge core_clk);
            took = msg_valid && msg_ready;
            if (took) id = msg_src;
            #1;
            if (took) begin
                turn++;
                stall = (turn % 2) * 3;
                eoi_wait = eoi_en ? stall + 1 : -1;
            end else if (msg_valid && stall > 0) begin
                stall--;
            end
            msg_ready = msg_valid && !took && stall == 0 && !srst;
            eoi_valid = eoi_wait == 0 && !srst;
            // idle id lines toggle so a stale value is never trusted
            eoi_src = eoi_valid ? id : ~eoi_src;
            if (eoi_wait >= 0) eoi_wait--;
        end
    end
endmodule
`default_nettype wire

// ==== idsrc_testbench.sv ====
// Purpose: self-checking bench for idsrc_top
// Assumes: host model on the message link
// Notes: register model in lo_m/hi_m, expected messages in exp_q
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import idsrc_pkg::*;
    localparam int NI = 4;
    logic core_clk, srst, cfg_rd, cfg_wr, cfg_dw_sel, cfg_rvalid;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [NI-1:0] src_in;
    logic posted_busy, msg_valid, msg_ready, msg_pass_pw, eoi_valid, eoi_en;
    logic [7:0] msg_src, eoi_src;
    idsrc_info_type msg_info;
    int n_mismatch, samples_checked, n_acc;
    int seed = 89067;
    logic [62:0] exp_q[$];
    logic [31:0] lo_m[NI], hi_m[NI];
    idsrc_top #(.NUM_INT(NI)) u_dut (
        .core_clk(core_clk), .srst(srst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_dw_sel(cfg_dw_sel), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .src_in(src_in), .posted_busy(posted_busy),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_info(msg_info),
        .msg_pass_pw(msg_pass_pw), .msg_src(msg_src), .eoi_valid(eoi_valid),
        .eoi_src(eoi_src));
    idsrc_host_model u_host (
        .core_clk(core_clk), .srst(srst), .msg_valid(msg_valid), .msg_src(msg_src),
        .eoi_en(eoi_en), .msg_ready(msg_ready), .eoi_valid(eoi_valid),
        .eoi_src(eoi_src));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // older posted writes come and go at random
    always @(posedge core_clk) posted_busy <= #1 ($random(seed) % 3 == 0);
    task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    always @(posedge core_clk) begin
        if (!srst && msg_valid === 1'b1 && msg_ready === 1'b1) begin
            n_acc++;
            if (exp_q.size() == 0) check("spare message", 64'h0, 64'h1);
            else check("message", exp_q.pop_front(), {msg_src, msg_pass_pw, msg_info});
        end
    end
    function automatic logic [7:0] idx(input int n, input int hi);
        return 8'h10 + 8'(2 * n + hi);
    endfunction
    task automatic cfg_op(input logic wr, input logic sel, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        cfg_wr = wr;
        cfg_rd = !wr;
        cfg_dw_sel = sel;
        cfg_wdata = d;
        @(posedge core_clk);
        #1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] i, input logic [31:0] d);
        cfg_op(1'b1, 1'b0, {8'h00, i, 16'h0000});
        cfg_op(1'b1, 1'b1, d);
    endtask
    task automatic rd_chk(input string w, input logic [7:0] i, input logic [31:0] e);
        cfg_op(1'b1, 1'b0, {8'h00, i, 16'h0000});
        cfg_op(1'b0, 1'b1, 32'h0000_0000);
        check(w, {1'b1, e}, {cfg_rvalid, cfg_rdata});
    endtask
    task automatic do_reset();
        srst = 1'b1;
        src_in = '0;
        repeat (5) @(posedge core_clk);
        #1;
        srst = 1'b0;
        for (int n = 0; n < NI; n++) begin
            lo_m[n] = 32'hF800_0001;
            hi_m[n] = 32'h0000_0000;
        end
    endtask
    task automatic defaults();
        for (int n = 0; n < NI; n++) begin
            rd_chk("low reset", idx(n, 0), 32'hF800_0001);
            rd_chk("high reset", idx(n, 1), 32'h0000_0000);
        end
        rd_chk("last intr", 8'h01, {8'h00, 8'(NI - 1), 16'h0000});
        rd_chk("reserved", 8'h02, 32'h0000_0000);
        cfg_op(1'b0, 1'b0, 32'h0000_0000);
        check("header", {1'b1, 32'h8002_0008}, {cfg_rvalid, cfg_rdata});
    endtask
    task automatic fire(input int n, input logic want);
        int k;
        int a;
        a = n_acc;
        k = 0;
        if (want) exp_q.push_back({8'(n), hi_m[n][30], hi_m[n][23:0], lo_m[n][31:2]});
        src_in[n] = !lo_m[n][1];
        while (n_acc == a && k < 40) begin
            @(posedge core_clk);
            k++;
        end
        #1;
        check("message count", 64'(want), 64'(n_acc - a));
        src_in[n] = lo_m[n][1];
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end
    initial begin
        int b;
        logic [31:0] r;
        n_mismatch = 0;
        samples_checked = 0;
        n_acc = 0;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_dw_sel = 1'b0;
        cfg_wdata = 32'h0000_0000;
        eoi_en = 1'b1;
        do_reset();
        defaults();
        for (int n = 0; n < NI; n++) begin
            r = $random(seed);
            b = $unsigned($random(seed)) % 249;
            lo_m[n] = {b[7:0], r[23:1], 1'b1};
            hi_m[n] = $random(seed) & 32'h40FF_FFFF;
            wr_reg(idx(n, 0), lo_m[n]);
            wr_reg(idx(n, 1), hi_m[n] | 32'h3F00_0000);
            src_in = $random(seed);
        end
        for (int n = 0; n < NI; n++) begin
            rd_chk("low rw", idx(n, 0), lo_m[n]);
            rd_chk("high rw", idx(n, 1), hi_m[n]);
        end
        // every message type, both polarities, both ordering modes
        for (int t = 0; t < 8; t++) begin
            r = $random(seed);
            lo_m[t % NI] = {8'hF8, r[17:0], t[2], t[2:0], t[0], 1'b1};
            hi_m[t % NI] = {1'b0, t[1], 6'h00, r[31:8]};
            wr_reg(idx(t % NI, 1), hi_m[t % NI]);
            wr_reg(idx(t % NI, 0), lo_m[t % NI]);
            src_in[t % NI] = t[0];
            lo_m[t % NI][0] = 1'b0;
            wr_reg(idx(t % NI, 0), lo_m[t % NI]);
            rd_chk("relax control", idx(t % NI, 1), hi_m[t % NI]);
            fire(t % NI, 1'b1);
        end
        lo_m[0][0] = 1'b1;
        wr_reg(idx(0, 0), lo_m[0]);
        fire(0, 1'b0);
        eoi_en = 1'b0;
        fire(1, 1'b1);
        rd_chk("eoi set", idx(1, 1), hi_m[1] | 32'h8000_0000);
        fire(1, 1'b0);
        wr_reg(idx(1, 1), hi_m[1] | 32'h8000_0000);
        rd_chk("eoi cleared", idx(1, 1), hi_m[1]);
        eoi_en = 1'b1;
        fire(1, 1'b1);
        repeat (20) @(posedge core_clk);
        rd_chk("eoi returned", idx(1, 1), hi_m[1]);
        do_reset();
        defaults();
        conclude();
    end
endmodule
`default_nettype wire
